/* File: hdl/usb_bus_event_pkg.sv */
// Constants shared by the device bus event status block and its line watcher.
// Assumes a 250 MHz system clock and an 8-bit register port.
package usb_bus_event_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 20;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'hb0;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'hb4;
  localparam logic [ADDR_W-1:0] OFS_NEGO = 8'hb8;
  localparam logic [ADDR_W-1:0] OFS_LINK = 8'hbc;
  localparam logic [ADDR_W-1:0] OFS_POWER = 8'hc0;
  localparam logic [ADDR_W-1:0] OFS_ADDRESS = 8'hc4;
  localparam logic [ADDR_W-1:0] OFS_ROLE = 8'hc8;

  // Status and enable bit positions
  localparam int ST_NON_IDLE = 6;
  localparam int ST_FRAME = 5;
  localparam int ST_RESET = 4;
  localparam int ST_SUSPEND = 3;
  localparam int ST_HANDSHAKE = 2;
  localparam int ST_RESTORE = 1;
  localparam int ST_ADDRESS = 0;
  localparam logic [DATA_W-1:0] STATUS_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] ROLE_GATED_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;

  // Negotiation control bit positions
  localparam int NC_ACTIVE = 7;
  localparam int NC_DETECT_DIS = 6;
  localparam int NC_HS_START = 5;
  localparam int NC_RESTORE = 4;
  localparam int NC_AUTO = 0;
  localparam logic [DATA_W-1:0] NEGO_RESET = 8'h00;

  // Link status, power control and role bit positions
  localparam int LS_SPEED = 0;
  localparam int LS_SUSPEND_ENTRY = 1;
  localparam int PC_SLEEP = 0;
  localparam int PC_SNOOZE = 1;
  localparam int RS_HOST = 0;

  // Line state coding
  localparam logic [1:0] LINE_SE0 = 2'b00;
  localparam logic [1:0] LINE_J = 2'b01;
  localparam logic [1:0] LINE_K = 2'b10;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int RESET_SE0_NS = 2500;
  localparam int RESET_SE0_CYC = (RESET_SE0_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_US = 3000;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int CHIRP_US = 1000;
  localparam int CHIRP_CYC = CHIRP_US * CLK_MHZ;
  localparam int RESUME_US = 1000;
  localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
endpackage

/* File: hdl/usb_bus_state_detect.sv */
// Line watcher: finds bus reset, bus suspend and the high-speed idle fallback.
// Assumes line_state_i is already synchronised to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module usb_bus_state_detect
#(
  parameter int IDLE_CYCLES = usb_bus_event_pkg::IDLE_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [1:0] line_state_i,
  input wire logic detect_en_i,
  input wire logic reset_en_i,
  input wire logic reset_blocked_i,
  input wire logic suspend_blocked_i,
  input wire logic hs_mode_i,
  output logic bus_reset_o,
  output logic bus_suspend_o,
  output logic fs_revert_o
);
  import usb_bus_event_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0] line_q;
  logic fired_q;
  logic fired_d;
  logic revert_q;
  logic revert_d;
  logic reset_d;
  logic suspend_d;

  always_comb
  begin
    cnt_d = cnt_q;
    fired_d = fired_q;
    revert_d = revert_q & hs_mode_i;
    reset_d = 1'b0;
    suspend_d = 1'b0;
    if (!detect_en_i || line_state_i != line_q)
    begin
      // Any bus activity restarts the episode
      cnt_d = '0;
      fired_d = 1'b0;
    end
    else if (!fired_q)
    begin
      cnt_d = cnt_q + CNT_W'(1);
      if (hs_mode_i && !revert_q)
      begin
        // HS idle is SE0; long silence switches to FS termination
        if (line_state_i == LINE_SE0 && cnt_q == CNT_W'(IDLE_CYCLES - 1))
        begin
          revert_d = 1'b1;
          cnt_d = '0;
        end
      end
      else if (line_state_i == LINE_SE0 && cnt_q == CNT_W'(RESET_SE0_CYC - 1))
      begin
        fired_d = 1'b1;
        reset_d = reset_en_i && !reset_blocked_i;
      end
      else if (line_state_i == LINE_J && (revert_q || cnt_q == CNT_W'(IDLE_CYCLES - 1)))
      begin
        fired_d = 1'b1;
        suspend_d = !suspend_blocked_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      line_q <= LINE_J;
      fired_q <= 1'b0;
      revert_q <= 1'b0;
      bus_reset_o <= 1'b0;
      bus_suspend_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      line_q <= line_state_i;
      fired_q <= fired_d;
      revert_q <= revert_d;
      bus_reset_o <= reset_d;
      bus_suspend_o <= suspend_d;
    end
  end

  assign fs_revert_o = revert_q;
endmodule
`default_nettype wire

/* File: hdl/usb_bus_event_status.sv */
// Device bus event status block: sticky bus events, interrupt, speed handshake,
// restore and sleep control. Assumes line state arrives raw from the transceiver
// and frame start and address completion pulses come from logic on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module usb_bus_event_status
#(
  parameter int IDLE_CYCLES = usb_bus_event_pkg::IDLE_CYC,
  parameter int CHIRP_CYCLES = usb_bus_event_pkg::CHIRP_CYC,
  parameter int RESUME_CYCLES = usb_bus_event_pkg::RESUME_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [usb_bus_event_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [usb_bus_event_pkg::DATA_W-1:0] reg_wr_data_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [usb_bus_event_pkg::DATA_W-1:0] reg_rd_data_o,
  input wire logic [1:0] line_state_i,
  input wire logic frame_start_token_i,
  input wire logic auto_address_status_done_i,
  input wire logic [6:0] auto_address_value_i,
  output logic interrupt_request_pin_o,
  output logic hs_termination_o,
  output logic drive_chirp_k_o,
  output logic drive_resume_k_o,
  output logic sleep_o,
  output logic [6:0] device_address_o
);
  import usb_bus_event_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CHIRP, SEQ_LISTEN, SEQ_RESUME} seq_e;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic rst_meta_q, rst_sync_q, rst_n;
  logic [1:0] line_meta_q, line_q;
  seq_e seq_q, seq_d;
  logic [CNT_W-1:0] seq_cnt_q, seq_cnt_d;
  logic chirp_seen_q, chirp_seen_d;
  logic handshake_done, restore_done, handshake_hs, handshake_start, restore_start;
  logic [DATA_W-1:0] status_q, status_d, enable_q, enable_d, nego_q, nego_d, power_q, power_d;
  logic [DATA_W-1:0] rd_data_d, event_set, clear_mask, role_view;
  logic role_host_q, role_host_d, hs_q, hs_d, saved_hs_q, saved_hs_d, suspend_entry_q, suspend_entry_d;
  logic [6:0] addr_q, addr_d;
  logic non_idle_en, suspended;
  logic bus_reset_ev, bus_suspend_ev, fs_revert;

  // Reset release and line state synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_meta_q <= LINE_J;
      line_q <= LINE_J;
    end
    else
    begin
      line_meta_q <= line_state_i;
      line_q <= line_meta_q;
    end
  end

  // Own chirp or resume K on the bus would look like activity, so hold detection off
  usb_bus_state_detect #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_detect (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .line_state_i(line_q),
    .detect_en_i(!nego_q[NC_DETECT_DIS] && seq_q == SEQ_IDLE),
    .reset_en_i(nego_q[NC_ACTIVE]),
    .reset_blocked_i(status_q[ST_SUSPEND]),
    .suspend_blocked_i(status_q[ST_RESET]),
    .hs_mode_i(hs_q),
    .bus_reset_o(bus_reset_ev),
    .bus_suspend_o(bus_suspend_ev),
    .fs_revert_o(fs_revert)
  );

  assign suspended = status_q[ST_SUSPEND] || suspend_entry_q;
  assign handshake_start = (reg_wr_i && hit(reg_addr_i, OFS_NEGO) && reg_wr_data_i[NC_HS_START]
                            && status_q[ST_RESET]) || (nego_q[NC_AUTO] && bus_reset_ev);
  assign restore_start = reg_wr_i && hit(reg_addr_i, OFS_NEGO) && reg_wr_data_i[NC_RESTORE] && suspended;
  assign handshake_hs = chirp_seen_q || line_q == LINE_K;

  // Speed handshake and restore sequencer
  always_comb
  begin
    seq_d = seq_q;
    seq_cnt_d = seq_cnt_q + CNT_W'(1);
    chirp_seen_d = chirp_seen_q;
    handshake_done = 1'b0;
    restore_done = 1'b0;
    case (seq_q)
      SEQ_IDLE:
      begin
        seq_cnt_d = '0;
        chirp_seen_d = 1'b0;
        if (restore_start)
          seq_d = SEQ_RESUME;
        else if (handshake_start)
          seq_d = SEQ_CHIRP;
      end
      SEQ_CHIRP:
      begin
        if (seq_cnt_q == CNT_W'(CHIRP_CYCLES - 1))
        begin
          seq_d = SEQ_LISTEN;
          seq_cnt_d = '0;
        end
      end
      SEQ_LISTEN:
      begin
        // Any host K while listening means the host speaks high speed
        if (line_q == LINE_K)
          chirp_seen_d = 1'b1;
        if (seq_cnt_q == CNT_W'(CHIRP_CYCLES - 1))
        begin
          seq_d = SEQ_IDLE;
          handshake_done = 1'b1;
        end
      end
      SEQ_RESUME:
      begin
        if (seq_cnt_q == CNT_W'(RESUME_CYCLES - 1))
        begin
          seq_d = SEQ_IDLE;
          restore_done = 1'b1;
        end
      end
      default:
        seq_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_q <= SEQ_IDLE;
      seq_cnt_q <= '0;
      chirp_seen_q <= 1'b0;
      drive_chirp_k_o <= 1'b0;
      drive_resume_k_o <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      seq_cnt_q <= seq_cnt_d;
      chirp_seen_q <= chirp_seen_d;
      drive_chirp_k_o <= seq_d == SEQ_CHIRP;
      drive_resume_k_o <= seq_d == SEQ_RESUME;
    end
  end

  // Registers, speed and power state
  always_comb
  begin
    role_view = role_host_q ? ~ROLE_GATED_MASK : 8'hff;
    non_idle_en = power_q[PC_SNOOZE] || (nego_q[NC_AUTO] && suspend_entry_q);
    event_set = '0;
    event_set[ST_NON_IDLE] = non_idle_en && line_q != LINE_J;
    event_set[ST_FRAME] = frame_start_token_i;
    event_set[ST_RESET] = bus_reset_ev;
    event_set[ST_SUSPEND] = bus_suspend_ev;
    event_set[ST_HANDSHAKE] = handshake_done;
    event_set[ST_RESTORE] = restore_done;
    event_set[ST_ADDRESS] = auto_address_status_done_i;
    clear_mask = '0;
    if (reg_wr_i && hit(reg_addr_i, OFS_STATUS))
      clear_mask = reg_wr_data_i & STATUS_MASK & role_view;
    // A new event wins over a clear in the same cycle
    status_d = ((status_q & ~clear_mask) | event_set) & STATUS_MASK;

    enable_d = enable_q;
    if (reg_wr_i && hit(reg_addr_i, OFS_ENABLE))
      enable_d = reg_wr_data_i & STATUS_MASK;

    nego_d = nego_q;
    if (reg_wr_i && hit(reg_addr_i, OFS_NEGO))
    begin
      nego_d[NC_ACTIVE] = reg_wr_data_i[NC_ACTIVE];
      nego_d[NC_DETECT_DIS] = reg_wr_data_i[NC_DETECT_DIS];
      nego_d[NC_AUTO] = reg_wr_data_i[NC_AUTO];
    end
    // Start bits read back as busy until their sequence ends
    if (seq_q == SEQ_IDLE && restore_start)
      nego_d[NC_RESTORE] = 1'b1;
    else if (seq_q == SEQ_IDLE && handshake_start)
      nego_d[NC_HS_START] = 1'b1;
    if (handshake_done)
      nego_d[NC_HS_START] = 1'b0;
    if (restore_done)
      nego_d[NC_RESTORE] = 1'b0;

    power_d = power_q;
    if (reg_wr_i && hit(reg_addr_i, OFS_POWER))
    begin
      power_d[PC_SNOOZE] = reg_wr_data_i[PC_SNOOZE];
      // Sleep is honoured only once the bus is suspended
      power_d[PC_SLEEP] = reg_wr_data_i[PC_SLEEP] && suspended;
    end
    // Bus activity or restore wakes the clocks again
    if (line_q != LINE_J || restore_start)
      power_d[PC_SLEEP] = 1'b0;

    role_host_d = role_host_q;
    if (reg_wr_i && hit(reg_addr_i, OFS_ROLE))
      role_host_d = reg_wr_data_i[RS_HOST];

    addr_d = addr_q;
    if (auto_address_status_done_i)
      addr_d = auto_address_value_i;

    hs_d = hs_q;
    saved_hs_d = saved_hs_q;
    suspend_entry_d = suspend_entry_q;
    if (bus_suspend_ev)
    begin
      saved_hs_d = hs_q;
      suspend_entry_d = 1'b1;
    end
    if (bus_reset_ev)
    begin
      hs_d = 1'b0;
      suspend_entry_d = 1'b0;
    end
    if (handshake_done)
      hs_d = handshake_hs;
    if (restore_done)
    begin
      hs_d = saved_hs_q;
      suspend_entry_d = 1'b0;
    end

    rd_data_d = '0;
    if (reg_rd_i)
    begin
      if (hit(reg_addr_i, OFS_STATUS))
        rd_data_d = status_q & role_view;
      else if (hit(reg_addr_i, OFS_ENABLE))
        rd_data_d = enable_q;
      else if (hit(reg_addr_i, OFS_NEGO))
        rd_data_d = nego_q;
      else if (hit(reg_addr_i, OFS_LINK))
      begin
        rd_data_d[LS_SPEED] = !hs_q;
        rd_data_d[LS_SUSPEND_ENTRY] = suspend_entry_q;
      end
      else if (hit(reg_addr_i, OFS_POWER))
        rd_data_d = power_q;
      else if (hit(reg_addr_i, OFS_ADDRESS))
        rd_data_d = {1'b0, addr_q};
      else if (hit(reg_addr_i, OFS_ROLE))
        rd_data_d[RS_HOST] = role_host_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= STATUS_RESET;
      enable_q <= '0;
      nego_q <= NEGO_RESET;
      power_q <= '0;
      role_host_q <= 1'b0;
      addr_q <= '0;
      hs_q <= 1'b0;
      saved_hs_q <= 1'b0;
      suspend_entry_q <= 1'b0;
      reg_rd_data_o <= '0;
      interrupt_request_pin_o <= 1'b0;
      hs_termination_o <= 1'b0;
      sleep_o <= 1'b0;
      device_address_o <= '0;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      nego_q <= nego_d;
      power_q <= power_d;
      role_host_q <= role_host_d;
      addr_q <= addr_d;
      hs_q <= hs_d;
      saved_hs_q <= saved_hs_d;
      suspend_entry_q <= suspend_entry_d;
      reg_rd_data_o <= rd_data_d;
      interrupt_request_pin_o <= |(status_q & enable_q);
      hs_termination_o <= hs_d && !fs_revert;
      sleep_o <= power_d[PC_SLEEP];
      device_address_o <= addr_d;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/usb_bus_event_status_assertions.sv */
// Checker on the ports of the device bus event status block.
// Assumes one clock domain and the register map of the shared package.
`timescale 1ns/1ps
`default_nettype none
module usb_bus_event_status_assertions
#(
  parameter int CHIRP_CYCLES = 20
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [usb_bus_event_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [usb_bus_event_pkg::DATA_W-1:0] reg_wr_data_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [usb_bus_event_pkg::DATA_W-1:0] reg_rd_data_o,
  input wire logic auto_address_status_done_i,
  input wire logic [6:0] auto_address_value_i,
  input wire logic interrupt_request_pin_o,
  input wire logic drive_chirp_k_o,
  input wire logic sleep_o,
  input wire logic [6:0] device_address_o
);
  import usb_bus_event_pkg::*;
  logic [7:0] en_q, en_d;
  logic role_q, role_d;
  logic [CNT_W-1:0] chirp_q, chirp_d;
  logic sleep_wr;
  assign sleep_wr = reg_wr_i && reg_addr_i == OFS_POWER && reg_wr_data_i[PC_SLEEP];
  // Shadows of enable and role, needed to know what the outputs may do
  always_comb
  begin
    en_d = (reg_wr_i && reg_addr_i == OFS_ENABLE) ? reg_wr_data_i : en_q;
    role_d = (reg_wr_i && reg_addr_i == OFS_ROLE) ? reg_wr_data_i[RS_HOST] : role_q;
    chirp_d = drive_chirp_k_o ? chirp_q + 1'b1 : '0;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_q <= 8'h00;
      role_q <= 1'b0;
      chirp_q <= '0;
    end
    else
    begin
      en_q <= en_d;
      role_q <= role_d;
      chirp_q <= chirp_d;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_read_idle;
    !reg_rd_i |=> reg_rd_data_o == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside read slot");
  property p_unmapped;
    reg_rd_i && reg_addr_i < OFS_STATUS |=> reg_rd_data_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status_gate;
    reg_rd_i && reg_addr_i == OFS_STATUS |=> !reg_rd_data_o[7] && (!$past(role_q) || reg_rd_data_o[5:0] == 6'h00);
  endproperty
  a_status_gate: assert property (p_status_gate)
    else $error("status bits visible in host role");
  property p_irq_off;
    en_q == 8'h00 && $past(en_q) == 8'h00 |-> !interrupt_request_pin_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables off");
  property p_irq_on;
    auto_address_status_done_i && en_q[ST_ADDRESS] && !role_q |-> ##[1:3] interrupt_request_pin_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled event gave no interrupt");
  property p_addr_load;
    auto_address_status_done_i && !role_q |=> device_address_o == $past(auto_address_value_i);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address not loaded with completion");
  property p_chirp_len;
    $fell(drive_chirp_k_o) |-> chirp_q == CNT_W'(CHIRP_CYCLES);
  endproperty
  a_chirp_len: assert property (p_chirp_len)
    else $error("handshake drive length wrong");
  property p_sleep_set;
    $rose(sleep_o) |-> $past(sleep_wr);
  endproperty
  a_sleep_set: assert property (p_sleep_set)
    else $error("sleep without request");
  c_chirp: cover property ($fell(drive_chirp_k_o));
  c_sleep: cover property ($rose(sleep_o));
  c_irq: cover property ($rose(interrupt_request_pin_o));
endmodule
bind usb_bus_event_status usb_bus_event_status_assertions #(.CHIRP_CYCLES(CHIRP_CYCLES)) i_usb_bus_event_status_assertions (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_data_i(reg_wr_data_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rd_data_o(reg_rd_data_o),
  .auto_address_status_done_i(auto_address_status_done_i), .auto_address_value_i(auto_address_value_i),
  .interrupt_request_pin_o(interrupt_request_pin_o), .drive_chirp_k_o(drive_chirp_k_o), .sleep_o(sleep_o),
  .device_address_o(device_address_o));
`default_nettype wire

/* File: testbench/usb_host_model.sv */
// Host side of the bus: line state and start-of-frame pulses.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
  input wire logic clk_sys_i,
  output logic [1:0] line_state_o,
  output logic frame_start_token_o
);
  import usb_bus_event_pkg::*;
  // Idle bus is J, held by the pull-up
  initial
  begin
    line_state_o = LINE_J;
    frame_start_token_o = 1'b0;
  end
  task automatic drive(input logic [1:0] s, input int n);
    line_state_o <= s;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic frame_start();
    frame_start_token_o <= 1'b1;
    @(posedge clk_sys_i);
    frame_start_token_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_usb_bus_event_status.sv */
// Bench for the device bus event status block with a host model on the line.
// Assumes shortened counts: idle 50, handshake and resume 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_usb_bus_event_status;
  import usb_bus_event_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, done = 1'b0, pend = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] aval = 7'h00, dev_addr;
  logic [1:0] line;
  logic sof, irq, hs, chirp, resume, sleep;
  logic [7:0] exp_q[$];
  int failures = 0;
  int total_checks = 0;
  initial
  begin
    forever #2 clk = ~clk;
  end
  usb_host_model i_usb_host_model (.clk_sys_i(clk), .line_state_o(line), .frame_start_token_o(sof));
  usb_bus_event_status #(.IDLE_CYCLES(50), .CHIRP_CYCLES(20), .RESUME_CYCLES(20)) i_usb_bus_event_status (
    .clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_data_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rd_data_o(rdata), .line_state_i(line), .frame_start_token_i(sof), .auto_address_status_done_i(done),
    .auto_address_value_i(aval), .interrupt_request_pin_o(irq), .hs_termination_o(hs), .drive_chirp_k_o(chirp),
    .drive_resume_k_o(resume), .sleep_o(sleep), .device_address_o(dev_addr));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Counts how long a sequencer drive stays up
  task automatic drive_len(input bit sel, input int len);
    int n;
    int hi;
    n = 0;
    hi = 0;
    while (n < 200 && (hi == 0 || (sel ? resume : chirp) === 1'b1))
    begin
      @(posedge clk);
      n++;
      if ((sel ? resume : chirp) === 1'b1)
        hi++;
    end
    check("drive length", 8'(hi), 8'(len));
  endtask
  // Old flags cleared with detection off, so one reset is seen once
  task automatic bus_reset(input logic [7:0] clr);
    wrt(OFS_NEGO, 8'h40);
    wrt(OFS_STATUS, clr);
    i_usb_host_model.drive(LINE_SE0, 1);
    wrt(OFS_NEGO, 8'h80);
    i_usb_host_model.drive(LINE_SE0, 60);
    check("hs", {7'h00, hs}, 8'h00);
    i_usb_host_model.drive(LINE_SE0, 640);
    i_usb_host_model.drive(LINE_J, 5);
    rdx(OFS_STATUS, 8'h10);
  endtask
  always @(posedge clk)
  begin
    if (pend)
      check("rd", rdata, exp_q.pop_front());
    pend = rd;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  initial
  begin
    void'($urandom(32'h540ffb62));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdx(OFS_STATUS, STATUS_RESET);
    wrt(OFS_NEGO, 8'h40);
    rdx(8'h10, 8'h00);
    wrt(OFS_POWER, 8'h01);
    wrt(OFS_ENABLE, 8'h00);
    i_usb_host_model.frame_start();
    rdx(OFS_STATUS, 8'h20);
    check("irq", {7'h00, irq}, 8'h00);
    check("sleep", {7'h00, sleep}, 8'h00);
    wrt(OFS_STATUS, 8'h00);
    wrt(OFS_ENABLE, STATUS_MASK);
    rdx(OFS_STATUS, 8'h20);
    check("irq", {7'h00, irq}, 8'h01);
    wrt(OFS_STATUS, 8'h20);
    @(posedge clk);
    aval <= 7'($urandom_range(127, 1));
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rdx(OFS_ADDRESS, {1'b0, aval});
    check("addr", {1'b0, dev_addr}, {1'b0, aval});
    wrt(OFS_ROLE, 8'h01);
    rdx(OFS_STATUS, 8'h00);
    wrt(OFS_STATUS, 8'h01);
    wrt(OFS_ROLE, 8'h00);
    rdx(OFS_STATUS, 8'h01);
    wrt(OFS_NEGO, 8'h00);
    i_usb_host_model.drive(LINE_SE0, 700);
    wrt(OFS_NEGO, 8'h40);
    i_usb_host_model.drive(LINE_J, 5);
    rdx(OFS_STATUS, 8'h01);
    bus_reset(8'h01);
    i_usb_host_model.drive(LINE_J, 80);
    rdx(OFS_STATUS, 8'h10);
    for (int m = 0; m < 2; m++)
    begin
      bus_reset(8'h14);
      wrt(OFS_NEGO, 8'ha0);
      drive_len(1'b0, 20);
      i_usb_host_model.drive(m ? LINE_K : LINE_J, 10);
      i_usb_host_model.drive(LINE_J, 40);
      rdx(OFS_STATUS, 8'h14);
      rdx(OFS_LINK, m ? 8'h00 : 8'h01);
    end
    check("hs", {7'h00, hs}, 8'h01);
    bus_reset(8'h14);
    wrt(OFS_NEGO, 8'h40);
    wrt(OFS_STATUS, 8'h10);
    wrt(OFS_NEGO, 8'h80);
    i_usb_host_model.drive(LINE_J, 80);
    rdx(OFS_STATUS, 8'h08);
    i_usb_host_model.drive(LINE_SE0, 700);
    i_usb_host_model.drive(LINE_J, 5);
    rdx(OFS_STATUS, 8'h08);
    wrt(OFS_POWER, 8'h03);
    @(posedge clk);
    check("sleep", {7'h00, sleep}, 8'h01);
    i_usb_host_model.drive(LINE_K, 5);
    i_usb_host_model.drive(LINE_J, 5);
    check("sleep", {7'h00, sleep}, 8'h00);
    wrt(OFS_NEGO, 8'h90);
    drive_len(1'b1, 20);
    repeat (3) @(posedge clk);
    rdx(OFS_STATUS, 8'h4a);
    repeat (3) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
